/* core/f2i_pkg.sv */
package f2i_pkg;
  // instruction codes on the host command port
  typedef enum logic [3:0] {
    OP_NONE, OP_CVT_SS, OP_CVT_SL, OP_CVT_DS, OP_CVT_DL, OP_LOAD_STATUS, OP_STORE_STATUS,
    OP_STORE_FAULT, OP_COPY_FLAGS, OP_SEL_SINGLE, OP_SEL_DOUBLE, OP_SEL_SHORT, OP_SEL_LONG, OP_FAULT_SET
  } op_t;
  // avalon register offsets (byte addresses)
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_OPND_HI = 5'h04;
  localparam logic [4:0] OFS_OPND_MID = 5'h08;
  localparam logic [4:0] OFS_OPND_LO = 5'h0C;
  localparam logic [4:0] OFS_DATA_IN = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_RESULT = 5'h18;
  localparam logic [4:0] OFS_FLAGS = 5'h1C;
  // status word fields
  localparam int DOUBLE_BIT_POS = 7;
  localparam int LONG_BIT_POS = 6;
  localparam int ERROR_BIT_POS = 15;
  localparam int INT_ENABLE_POS = 14;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // conversion constants (octal as printed)
  localparam logic [9:0] EXP_BIAS_ONE = 10'o201;
  localparam logic [9:0] SHORT_RANGE = 10'o17;
  localparam logic [9:0] LONG_RANGE = 10'o37;
  localparam logic [9:0] SHIFT_BASE = 10'o10;
  localparam logic [7:0] SPECIAL_EXP = 8'o220;
  localparam int FIELD_MSB = 50;
  localparam int SHORT_LSB = 35;
  localparam int LONG_LSB = 19;
  localparam int MASK_MSB = 59;
  localparam int MASK_LSB = 44;
  localparam int SPECIAL_SHIFT = 9;
  localparam logic [3:0] FAULT_CVT = 4'h3;
  localparam logic [15:0] TRAP_VECTOR = 16'o244;
endpackage

/* core/f2i_store_status.sv */
`timescale 1ns/100ps
module f2i_store_status
  import f2i_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic busy,
  output logic trap_req,
  output logic [15:0] trap_vector,
  output logic [3:0] host_ccodes
);
  typedef enum {S_IDLE, S_RANGE, S_ALIGN, S_NEGATE, S_SPECIAL, S_DONE} state_t;
  typedef struct packed {
    state_t st;
    logic [59:0] fraction_work_reg;
    logic [9:0] exponent_work_reg;
    logic [59:0] quotient_work_reg;
    logic [59:0] alu_operand_hold;
    logic operand_sign_flag;
    logic [59:0] scratch_acc_six;
    logic [31:0] store_output_buffer;
    logic [15:0] status_word_reg;
    logic [15:0] fault_address;
    logic [15:0] fault_code;
    logic [15:0] instr_addr;
    logic [15:0] data_in;
    logic [3:0] flags;
    logic is_long;
    logic ack;
    logic [31:0] rd;
    logic trap;
    logic [1:0] fault_idx;
  } state_s_t;
  state_s_t cur_reg, nxt;

  function automatic logic [59:0] field_inc(input logic lng);
    field_inc = lng ? (60'h1 << LONG_LSB) : (60'h1 << SHORT_LSB);
  endfunction

  logic [9:0] unbiased;
  logic [9:0] reduced;
  logic [9:0] shamt;
  logic [59:0] mask;
  logic [59:0] probe;
  logic [31:0] result_field;
  logic wr_take;
  logic rd_take;
  always_comb
  begin
    nxt = cur_reg;
    nxt.ack = 1'b0;
    nxt.trap = 1'b0;
    unbiased = cur_reg.exponent_work_reg - EXP_BIAS_ONE;
    reduced = unbiased - (cur_reg.is_long ? LONG_RANGE : SHORT_RANGE);
    shamt = 10'(SHIFT_BASE - reduced);
    mask = '0;
    mask[MASK_MSB:MASK_LSB] = '1;
    probe = ((cur_reg.fraction_work_reg & cur_reg.quotient_work_reg) << 1) - 60'h1;
    result_field = cur_reg.is_long ? cur_reg.scratch_acc_six[FIELD_MSB:LONG_LSB]
                                   : {16'h0000, cur_reg.scratch_acc_six[FIELD_MSB:SHORT_LSB]};
    wr_take = write && !cur_reg.ack;
    rd_take = read && !cur_reg.ack;
    if (wr_take || rd_take)
      nxt.ack = 1'b1;
    if (rd_take)
    begin
      unique case (address)
        OFS_STATUS: nxt.rd = {16'h0000, cur_reg.status_word_reg};
        OFS_RESULT: nxt.rd = cur_reg.store_output_buffer;
        OFS_FLAGS: nxt.rd = {27'h0, cur_reg.st != S_IDLE, cur_reg.flags};
        OFS_CMD: nxt.rd = {cur_reg.fault_code[3:0], cur_reg.fault_address, 12'h000};
        default: nxt.rd = 32'h0000_0000;
      endcase
    end
    if (wr_take)
    begin
      unique case (address)
        OFS_OPND_HI:
        begin
          nxt.operand_sign_flag = writedata[15];
          nxt.exponent_work_reg = {2'b00, writedata[14:7]};
          nxt.fraction_work_reg[59:51] = {2'b01, writedata[6:0]}; // hidden bit at 58
        end
        OFS_OPND_MID: nxt.fraction_work_reg[50:19] = writedata;
        OFS_OPND_LO: nxt.fraction_work_reg[18:3] = writedata[15:0];
        OFS_DATA_IN: nxt.data_in = writedata[15:0];
        OFS_CMD:
        if (cur_reg.st == S_IDLE)
        begin
          nxt.instr_addr = writedata[31:16];
          unique case (op_t'(writedata[3:0]))
            OP_CVT_SS, OP_CVT_SL, OP_CVT_DS, OP_CVT_DL:
            begin
              nxt.is_long = writedata[3:0] == 4'(OP_CVT_SL) || writedata[3:0] == 4'(OP_CVT_DL);
              if (writedata[3:0] == 4'(OP_CVT_SS) || writedata[3:0] == 4'(OP_CVT_SL))
                nxt.fraction_work_reg[26:0] = '0;
              nxt.scratch_acc_six = '0;
              nxt.st = S_RANGE;
            end
            OP_LOAD_STATUS: nxt.status_word_reg = cur_reg.data_in;
            OP_STORE_STATUS: nxt.store_output_buffer = {16'h0000, cur_reg.status_word_reg};
            OP_STORE_FAULT:
              nxt.store_output_buffer = (writedata[6:4] == 3'h0) ? {28'h0, cur_reg.fault_code[3:0]}
                                                                 : {12'h0, cur_reg.fault_code[3:0], cur_reg.fault_address};
            OP_COPY_FLAGS: nxt.flags = cur_reg.flags;
            OP_SEL_SINGLE: nxt.status_word_reg[DOUBLE_BIT_POS] = 1'b0;
            OP_SEL_DOUBLE: nxt.status_word_reg[DOUBLE_BIT_POS] = 1'b1;
            OP_SEL_SHORT: nxt.status_word_reg[LONG_BIT_POS] = 1'b0;
            OP_SEL_LONG: nxt.status_word_reg[LONG_BIT_POS] = 1'b1;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    unique case (cur_reg.st)
      S_IDLE: ;
      S_RANGE:
      begin
        nxt.flags = '0;
        nxt.flags[2] = 1'b0;
        if (unbiased[9])
        begin
          nxt.flags[2] = 1'b1;
          nxt.scratch_acc_six = '0;
          nxt.st = S_DONE;
        end
        else if (reduced == 10'h000)
        begin
          if (!cur_reg.is_long && cur_reg.operand_sign_flag && cur_reg.exponent_work_reg[7:0] == SPECIAL_EXP)
          begin
            nxt.quotient_work_reg = mask;
            nxt.st = S_SPECIAL;
          end
          else
            nxt.st = S_IDLE;
          if (!(!cur_reg.is_long && cur_reg.operand_sign_flag && cur_reg.exponent_work_reg[7:0] == SPECIAL_EXP))
          begin
            nxt.fault_code = {12'h000, FAULT_CVT};
            nxt.fault_address = cur_reg.instr_addr;
            nxt.status_word_reg[ERROR_BIT_POS] = 1'b1;
            nxt.trap = cur_reg.status_word_reg[INT_ENABLE_POS];
            nxt.scratch_acc_six = '0;
          end
        end
        else if (!reduced[9])
        begin
          nxt.flags[0] = 1'b0;
          nxt.scratch_acc_six = '0;
          nxt.st = S_DONE;
        end
        else
          nxt.st = S_ALIGN;
      end
      S_ALIGN:
      begin
        nxt.scratch_acc_six = (cur_reg.fraction_work_reg >> shamt) & (cur_reg.is_long
          ? {9'h0, 32'hFFFF_FFFF, 19'h0} : {9'h0, 16'hFFFF, 35'h0});
        nxt.st = cur_reg.operand_sign_flag ? S_NEGATE : S_DONE;
      end
      S_NEGATE:
      begin
        nxt.alu_operand_hold = ~cur_reg.scratch_acc_six;
        nxt.scratch_acc_six = (~cur_reg.scratch_acc_six + field_inc(cur_reg.is_long))
          & (cur_reg.is_long ? {9'h0, 32'hFFFF_FFFF, 19'h0} : {9'h0, 16'hFFFF, 35'h0});
        nxt.flags[3] = 1'b1;
        nxt.st = S_DONE;
      end
      S_SPECIAL:
      begin
        if (!probe[MASK_MSB])
          nxt.scratch_acc_six = (probe + 60'h1) >> SPECIAL_SHIFT;
        else
        begin
          nxt.fault_code = {12'h000, FAULT_CVT};
          nxt.fault_address = cur_reg.instr_addr;
          nxt.status_word_reg[ERROR_BIT_POS] = 1'b1;
          nxt.trap = cur_reg.status_word_reg[INT_ENABLE_POS];
        end
        nxt.flags[3] = 1'b1;
        nxt.st = probe[MASK_MSB] ? S_IDLE : S_DONE;
      end
      S_DONE:
      begin
        nxt.store_output_buffer = result_field;
        nxt.st = S_IDLE;
      end
      default: nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur_reg <= '0;
      cur_reg.st <= S_IDLE;
      cur_reg.status_word_reg <= STATUS_RESET;
    end
    else
      cur_reg <= nxt;
  end

  assign waitrequest = (read || write) && !cur_reg.ack;
  assign readdata = cur_reg.rd;
  assign busy = cur_reg.st != S_IDLE;
  assign trap_req = cur_reg.trap;
  assign trap_vector = TRAP_VECTOR;
  assign host_ccodes = cur_reg.flags;

  chk_zero_store: assert property (@(posedge clk) disable iff (rst)
    (cur_reg.st == S_RANGE && unbiased[9]) |=> (cur_reg.flags[2] && cur_reg.scratch_acc_six == '0))
    else $error("small operand not stored as zero");
  chk_overflow_zero: assert property (@(posedge clk) disable iff (rst)
    (cur_reg.st == S_RANGE && !unbiased[9] && !reduced[9] && reduced != 0) |=> ##1 (cur_reg.store_output_buffer == 0))
    else $error("overflow did not store zeros");
  chk_positive_path: assert property (@(posedge clk) disable iff (rst)
    (cur_reg.st == S_ALIGN && !cur_reg.operand_sign_flag) |=> cur_reg.st == S_DONE)
    else $error("positive operand negated");
  chk_trap_enable: assert property (@(posedge clk) disable iff (rst)
    trap_req |-> $past(cur_reg.status_word_reg[INT_ENABLE_POS]))
    else $error("trap without enable");
  chk_error_bit: assert property (@(posedge clk) disable iff (rst)
    $rose(trap_req) |-> cur_reg.status_word_reg[ERROR_BIT_POS] && cur_reg.fault_code[3:0] == FAULT_CVT)
    else $error("error bit not set on fault");
  chk_bus_answer: assert property (@(posedge clk) disable iff (rst)
    (read || write) && waitrequest |=> !waitrequest || !(read || write))
    else $error("bus answer late");
  chk_done_out: assert property (@(posedge clk) disable iff (rst)
    cur_reg.st == S_DONE |=> cur_reg.store_output_buffer == $past(result_field))
    else $error("result not buffered");
  chk_long_sel: assert property (@(posedge clk) disable iff (rst)
    (write && !cur_reg.ack && address == OFS_CMD && cur_reg.st == S_IDLE && writedata[3:0] == 4'(OP_SEL_LONG))
      |=> cur_reg.status_word_reg[LONG_BIT_POS])
    else $error("long select failed");
endmodule

/* dv/host_model.sv */
`timescale 1ns/100ps
module host_model
(
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [4:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata
);
  initial
  begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
  end
  // one bus cycle, held until waitrequest is low at a rising edge
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0)
      @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import f2i_pkg::*;
;
  typedef struct {op_t op; logic [15:0] hi; logic [31:0] res;} row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address;
  logic read, write, waitrequest, busy, trap_req;
  logic [31:0] writedata, readdata, q;
  logic [15:0] trap_vector;
  logic [3:0] host_ccodes;
  int num_errors = 0;
  int checks = 0;
  int trap_count = 0;
  int t0;
  row_t rows[8] = '{'{OP_CVT_SS, 16'h4180, 32'h4}, '{OP_CVT_SS, 16'h4000, 32'h0}, '{OP_CVT_SS, 16'h4880, 32'h0},
    '{OP_CVT_SS, 16'hC180, 32'hFFFC}, '{OP_CVT_SS, 16'hC800, 32'h8000}, '{OP_CVT_SL, 16'h4C00, 32'h00800000},
    '{OP_CVT_DL, 16'hCC00, 32'hFF800000}, '{OP_CVT_DS, 16'h4140, 32'h3}};
  op_t modes[4] = '{OP_SEL_SINGLE, OP_SEL_SHORT, OP_SEL_DOUBLE, OP_SEL_LONG};
  logic [15:0] mexp[4] = '{16'h0043, 16'h0003, 16'h0083, 16'h00C3};
  always #10 clk = ~clk;
  always @(posedge clk)
    if (trap_req === 1'b1)
      trap_count <= trap_count + 1;
  f2i_store_status i_dut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .busy(busy),
    .trap_req(trap_req), .trap_vector(trap_vector), .host_ccodes(host_ccodes));
  host_model host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata), .address(address),
    .read(read), .write(write), .writedata(writedata));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic op_cmd(input op_t op);
    logic [31:0] r;
    host.xfer(1'b1, OFS_CMD, {16'h0100, 12'h000, op}, r);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    host.xfer(1'b0, a, 32'h0, r);
  endtask
  // operand high word only; low fraction words zero
  task automatic cvt(input op_t op, input logic [15:0] hi, output logic [31:0] r);
    wr(OFS_OPND_HI, {16'h0000, hi});
    wr(OFS_OPND_MID, 32'h0);
    wr(OFS_OPND_LO, 32'h0);
    op_cmd(op);
    r = 32'h10;
    while (r[4] !== 1'b0)
      rd(OFS_FLAGS, r);
    rd(OFS_RESULT, r);
  endtask
  initial
  begin
    repeat (6000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_STATUS, q);
    check("status_reset", q, {16'h0, STATUS_RESET});
    check("ccodes_reset", host_ccodes, 4'h0);
    for (int i = 0; i < 8; i++)
    begin
      cvt(rows[i].op, rows[i].hi, q);
      if (rows[i].op == OP_CVT_SS || rows[i].op == OP_CVT_DS)
        q = q & 32'h0000FFFF;
      check("cvt_result", q, rows[i].res);
    end
    wr(OFS_DATA_IN, 32'h000000C3);
    op_cmd(OP_LOAD_STATUS);
    rd(OFS_STATUS, q);
    check("status_load", q[15:0], 16'h00C3);
    for (int i = 0; i < 4; i++)
    begin
      op_cmd(modes[i]);
      rd(OFS_STATUS, q);
      check("status_mode", q[15:0], mexp[i]);
    end
    cvt(OP_CVT_SS, 16'h4000, q);
    op_cmd(OP_COPY_FLAGS);
    rd(OFS_FLAGS, q);
    check("ccodes_zero", host_ccodes[2], 1'b1);
    t0 = trap_count;
    cvt(OP_CVT_SS, 16'h4800, q);
    rd(OFS_STATUS, q);
    check("error_bit", q[ERROR_BIT_POS], 1'b1);
    rd(OFS_CMD, q);
    check("fault_code", q[31:28], FAULT_CVT);
    check("fault_addr", q[27:12], 16'h0100);
    op_cmd(OP_STORE_FAULT);
    rd(OFS_RESULT, q);
    check("fault_mode0", q, {28'h0, FAULT_CVT});
    wr(OFS_CMD, {16'h0100, 9'h000, 3'h1, 4'(OP_STORE_FAULT)});
    rd(OFS_RESULT, q);
    check("fault_mode1", q, {12'h000, FAULT_CVT, 16'h0100});
    check("no_trap", trap_count, t0);
    wr(OFS_DATA_IN, 32'h00004000);
    op_cmd(OP_LOAD_STATUS);
    cvt(OP_CVT_SS, 16'hC840, q);
    rd(OFS_STATUS, q);
    check("special_reject", q[ERROR_BIT_POS], 1'b1);
    check("trap_pulse", trap_count, t0 + 1);
    check("trap_vector", trap_vector, 16'o244);
    rd(5'h02, q);
    check("unmapped", q, 32'h0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_STATUS, q);
    check("status_rereset", q, {16'h0, STATUS_RESET});
    print_verdict();
  end
endmodule
